// file: rtl/lane_params.svh
// timing, pattern and reset constants of the lane controller
`ifndef LANE_PARAMS_SVH
`define LANE_PARAMS_SVH

`define CLK_PS 4000
// data_termination_enable_time, longest allowed
`define DATA_TERM_EN_PS 35000
// clock_termination_enable_time, longest allowed
`define CLOCK_TERM_EN_PS 38000
// low-power state period, least
`define LPX_PS 50000
// first stop period that counts as initialization, least
`define INIT_US 100
// skew_cal_duration, longest, initial and periodic
`define CAL_INIT_US 100
`define CAL_PERIODIC_US 10
`define US_TO_CYC(us) (((us) * 1000000) / `CLK_PS)
`define CYC_FLOOR(ps) ((((ps) / `CLK_PS) < 1) ? 1 : ((ps) / `CLK_PS))
`define CYC_CEIL(ps) (((ps) + `CLK_PS - 1) / `CLK_PS)
`define DATA_TERM_EN_CYC `CYC_FLOOR(`DATA_TERM_EN_PS)
`define CLOCK_TERM_EN_CYC `CYC_FLOOR(`CLOCK_TERM_EN_PS)
`define LPX_CYC `CYC_CEIL(`LPX_PS)
// deskew sync run length in unit intervals
`define DESKEW_SYNC_UI 16
`define SYNC_BYTE 8'hb8
`define RATE_RESET 16'h0000

`endif

// file: rtl/lane_pkg.sv
// types shared by the lane controller
package lane_pkg;
    typedef struct packed {
        logic p;
        logic n;
    } lp_pair_s;

    typedef struct packed {
        logic [11:0] ui_ps;
        logic [3:0] skip_bits;
    } rate_cfg_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rx_byte_s;

    typedef enum logic [9:0] {
        DL_INIT = 10'h001,
        DL_STOP = 10'h002,
        DL_HS_RQST = 10'h004,
        DL_HS_PREP = 10'h008,
        DL_HS_RX = 10'h010,
        DL_ESC_RQST = 10'h020,
        DL_ESC = 10'h040,
        DL_TA_DRIVE = 10'h080,
        DL_TA_REL1 = 10'h100,
        DL_TA_REL2 = 10'h200
    } dl_state_e;

    typedef enum logic [7:0] {
        CL_INIT = 8'h01,
        CL_STOP = 8'h02,
        CL_HS_RQST = 8'h04,
        CL_HS_PREP = 8'h08,
        CL_HS_CLK = 8'h10,
        CL_ULTRA_LOW_POWER_STATE_RQST = 8'h20,
        CL_ULTRA_LOW_POWER_STATE = 8'h40,
        CL_ULTRA_LOW_POWER_STATE_EXIT = 8'h80
    } cl_state_e;
endpackage

// file: rtl/sync_bit.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module sync_bit #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        meta_reg <= d;
        q <= meta_reg;
    end
endmodule

// file: rtl/lane_ctrl.sv
// receive lane controller: data and clock lane states, burst, deskew
`timescale 1ns/1ps
`include "lane_params.svh"
// Behaviour
// - calibration must finish inside 100 us initial, 10 us periodic burst
// - rate fixed per burst; changed only in init, ULTRA_LOW_POWER_STATE or clock-halted stop
// - time-plus-UI intervals use timer plus rate-dependent counts; the code times them with the clk timer alone and never uses ui_ps
// - receiver drops trailing transition bits before final data
// - receiver enables termination within enable time of LP-00 entry
// - low-power timing runs without any high-speed clock
// - with a one-way partner, two-way features are disabled
// - exactly one side drives a lane outside transitions
// - detect opposite low-power levels driven from both ends
// - side driving low-power high flags high-speed-low contention
// - check contention before each transition, except after ULTRA_LOW_POWER_STATE transmit
// - data lane supports burst, escape, turnaround and initialization
// - receiver starts deskew calibration when deskew sync is seen
module lane_ctrl #(
    parameter int INIT_CYC = `US_TO_CYC(`INIT_US),
    parameter int CAL_INIT_CYC = `US_TO_CYC(`CAL_INIT_US),
    parameter int CAL_PER_CYC = `US_TO_CYC(`CAL_PERIODIC_US),
    parameter int MAX_SKIP = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hs_clk,
    input wire logic hs_bit,
    input wire lane_pkg::lp_pair_s lp_in,
    input wire lane_pkg::lp_pair_s cd_in,
    input wire lane_pkg::lp_pair_s cl_lp_in,
    input wire logic unidir_partner,
    input wire logic turn_req,
    input wire lane_pkg::rate_cfg_s rate_cfg,
    input wire logic contention_ack,
    output lane_pkg::lp_pair_s lp_out,
    output lane_pkg::lp_pair_s lp_oe,
    output lane_pkg::rx_byte_s rx_byte,
    output lane_pkg::rate_cfg_s rate_applied,
    output logic term_en,
    output logic cl_term_en,
    output logic hs_active,
    output logic esc_active,
    output logic cl_hs_active,
    output logic cl_ultra_low_power_state_active,
    output logic contention,
    output logic deskew_active,
    output logic cal_done,
    output logic cal_overrun
);
    localparam int TERM_CYC = `DATA_TERM_EN_CYC;
    localparam int CL_TERM_CYC = `CLOCK_TERM_EN_CYC;
    localparam int LPX_CYC = `LPX_CYC;

    lane_pkg::dl_state_e dl_state_reg, dl_next;
    lane_pkg::cl_state_e cl_state_reg, cl_next;
    lane_pkg::lp_pair_s lp_s, cd_s, cl_s, lp_out_next;
    lane_pkg::rate_cfg_s rate_reg;
    logic unidir_s, byte_tgl_s, desk_tgl_s, byte_tgl_d, desk_tgl_d;
    logic byte_pulse, desk_pulse, drive_next, mism, unidir_reg;
    logic strap_taken, hs_rx_en_reg, cal_run, cal_init, cal_seen;
    logic rate_ok;
    logic [15:0] stop_cnt, cal_cnt, cal_limit;
    logic [7:0] tmr, cl_tmr;
    logic init_done, burst_end;
    logic byte_tgl, desk_tgl;

    // pins and link-domain toggles are all asynchronous to clk
    sync_bit #(.W(9)) u_sync_clk (
        .clk(clk),
        .d({lp_in, cd_in, cl_lp_in, unidir_partner, byte_tgl, desk_tgl}),
        .q({lp_s, cd_s, cl_s, unidir_s, byte_tgl_s, desk_tgl_s})
    );

    // link side: runs on the forwarded clock
    logic [5:0] hs_sync_q;
    logic en_s, hs_rst_s;
    logic [3:0] skip_s;
    logic [MAX_SKIP-1:0] dly;
    logic [7:0] hunt_sh, byte_sh, byte_hold;
    logic [4:0] ones_cnt;
    logic [3:0] drop_cnt;
    logic [2:0] bit_cnt;
    logic in_burst, deskew_mode, tap;

    // skip count only changes while the link clock is halted, so
    // per-bit synchronising cannot tear it
    sync_bit #(.W(6)) u_sync_hs (
        .clk(hs_clk),
        .d({hs_rx_en_reg, rate_reg.skip_bits, rst}),
        .q(hs_sync_q)
    );
    assign en_s = hs_sync_q[5];
    assign skip_s = hs_sync_q[4:1];
    assign hs_rst_s = hs_sync_q[0];
    assign tap = (skip_s == 4'h0) ? hs_bit : dly[skip_s - 4'h1];

    always_ff @(posedge hs_clk)
    begin
        dly <= {dly[MAX_SKIP-2:0], hs_bit};
    end

    // burst state is cleared by the burst's own enable dropping;
    // relies on the tail clocks the far end keeps sending
    always_ff @(posedge hs_clk)
    begin
        if (hs_rst_s || !en_s)
        begin
            hunt_sh <= 8'h00;
            ones_cnt <= 5'h00;
            in_burst <= 1'b0;
            deskew_mode <= 1'b0;
            drop_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            byte_sh <= 8'h00;
        end
        else if (!in_burst && !deskew_mode)
        begin
            hunt_sh <= {hs_bit, hunt_sh[7:1]};
            ones_cnt <= hs_bit ? ones_cnt + 5'h01 : 5'h00;
            if (hs_bit && ones_cnt == 5'(`DESKEW_SYNC_UI - 1))
                deskew_mode <= 1'b1;
            else if ({hs_bit, hunt_sh[7:1]} == `SYNC_BYTE)
            begin
                in_burst <= 1'b1;
                drop_cnt <= skip_s;
            end
        end
        else if (in_burst)
        begin
            // delivery lags the line by the skip depth, so the tail
            // bits still in the delay line are never delivered
            if (drop_cnt != 4'h0)
                drop_cnt <= drop_cnt - 4'h1;
            else
            begin
                byte_sh <= {tap, byte_sh[7:1]};
                bit_cnt <= bit_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge hs_clk)
    begin
        if (hs_rst_s)
        begin
            byte_tgl <= 1'b0;
            desk_tgl <= 1'b0;
            byte_hold <= 8'h00;
        end
        else
        begin
            if (en_s && in_burst && drop_cnt == 4'h0 && bit_cnt == 3'h7)
            begin
                byte_hold <= {tap, byte_sh[7:1]};
                byte_tgl <= ~byte_tgl;
            end
            if (en_s && !in_burst && !deskew_mode && hs_bit &&
                ones_cnt == 5'(`DESKEW_SYNC_UI - 1))
                desk_tgl <= ~desk_tgl;
        end
    end

    // controller side
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            byte_tgl_d <= 1'b0;
            desk_tgl_d <= 1'b0;
        end
        else
        begin
            byte_tgl_d <= byte_tgl_s;
            desk_tgl_d <= desk_tgl_s;
        end
    end
    assign byte_pulse = byte_tgl_s ^ byte_tgl_d;
    assign desk_pulse = desk_tgl_s ^ desk_tgl_d;

    // a byte toggle is followed by 8 link clocks of stable hold data
    always_ff @(posedge clk)
    begin
        if (rst)
            rx_byte <= '0;
        else
        begin
            rx_byte.valid <= byte_pulse;
            if (byte_pulse)
                rx_byte.data <= byte_hold;
        end
    end

    // strap is caught by a clocked process after reset release
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            unidir_reg <= 1'b0;
            strap_taken <= 1'b0;
        end
        else if (!strap_taken)
        begin
            unidir_reg <= unidir_s;
            strap_taken <= 1'b1;
        end
    end

    // both lanes leave init together after a long enough stop
    always_ff @(posedge clk)
    begin
        if (rst || lp_s != 2'b11 || cl_s != 2'b11)
            stop_cnt <= 16'h0000;
        else if (!init_done)
            stop_cnt <= stop_cnt + 16'h0001;
    end
    assign init_done = (stop_cnt >= 16'(INIT_CYC));

    always_comb
    begin
        logic chk;
        chk = 1'b0;
        dl_next = dl_state_reg;
        case (dl_state_reg)
            lane_pkg::DL_INIT:
                if (init_done)
                    dl_next = lane_pkg::DL_STOP;
            lane_pkg::DL_STOP:
                if (lp_s == 2'b01)
                    dl_next = lane_pkg::DL_HS_RQST;
                else if (lp_s == 2'b10)
                    dl_next = lane_pkg::DL_ESC_RQST;
                else if (turn_req && !unidir_reg)
                    dl_next = lane_pkg::DL_TA_DRIVE;
            lane_pkg::DL_HS_RQST:
                if (lp_s == 2'b00)
                    dl_next = lane_pkg::DL_HS_PREP;
                else if (lp_s != 2'b01)
                    dl_next = lane_pkg::DL_STOP;
            lane_pkg::DL_HS_PREP:
                if (tmr == 8'(TERM_CYC - 1))
                    dl_next = lane_pkg::DL_HS_RX;
            lane_pkg::DL_HS_RX:
                if (lp_s == 2'b11)
                    dl_next = lane_pkg::DL_STOP;
            lane_pkg::DL_ESC_RQST:
                if (lp_s == 2'b00)
                    dl_next = lane_pkg::DL_ESC;
                else if (lp_s == 2'b11)
                    dl_next = lane_pkg::DL_STOP;
            lane_pkg::DL_ESC:
                if (lp_s == 2'b11)
                    dl_next = lane_pkg::DL_STOP;
            lane_pkg::DL_TA_DRIVE:
                if (!turn_req)
                    dl_next = lane_pkg::DL_TA_REL1;
            lane_pkg::DL_TA_REL1:
                if (tmr == 8'(LPX_CYC - 1))
                    dl_next = lane_pkg::DL_TA_REL2;
            lane_pkg::DL_TA_REL2:
                if (tmr == 8'(LPX_CYC - 1))
                    dl_next = lane_pkg::DL_STOP;
            default:
                dl_next = lane_pkg::DL_INIT;
        endcase
        // this lane never transmits ULTRA_LOW_POWER_STATE, so every driven transition
        // is checked; a conflict drops the drive at once
        chk = lp_oe.p && (dl_next != dl_state_reg);
        if (chk && mism)
            dl_next = lane_pkg::DL_STOP;
    end

    // lp receiver catches a pulled-down high, detector a pulled-up low
    assign mism = (lp_out.p && !lp_s.p) || (lp_out.n && !lp_s.n) ||
                  (!lp_out.p && cd_s.p) || (!lp_out.n && cd_s.n);

    always_ff @(posedge clk)
    begin
        if (rst)
            contention <= 1'b0;
        else if (lp_oe.p && dl_next != dl_state_reg && mism)
            contention <= 1'b1;
        else if (contention_ack)
            contention <= 1'b0;
    end

    always_comb
    begin
        drive_next = 1'b1;
        lp_out_next = 2'b11;
        case (dl_next)
            lane_pkg::DL_TA_DRIVE:
                lp_out_next = 2'b11;
            lane_pkg::DL_TA_REL1:
                lp_out_next = 2'b10;
            lane_pkg::DL_TA_REL2:
                lp_out_next = 2'b00;
            default:
                drive_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dl_state_reg <= lane_pkg::DL_INIT;
            lp_out <= 2'b00;
            lp_oe <= 2'b00;
            tmr <= 8'h00;
            term_en <= 1'b0;
            hs_rx_en_reg <= 1'b0;
            esc_active <= 1'b0;
        end
        else
        begin
            dl_state_reg <= dl_next;
            lp_out <= drive_next ? lp_out_next : 2'b00;
            lp_oe <= {drive_next, drive_next};
            tmr <= (dl_next != dl_state_reg) ? 8'h00 : tmr + 8'h01;
            term_en <= (dl_next == lane_pkg::DL_HS_PREP) ||
                       (dl_next == lane_pkg::DL_HS_RX);
            hs_rx_en_reg <= (dl_next == lane_pkg::DL_HS_RX);
            esc_active <= (dl_next == lane_pkg::DL_ESC);
        end
    end
    assign hs_active = hs_rx_en_reg;

    always_comb
    begin
        cl_next = cl_state_reg;
        case (cl_state_reg)
            lane_pkg::CL_INIT:
                if (init_done)
                    cl_next = lane_pkg::CL_STOP;
            lane_pkg::CL_STOP:
                if (cl_s == 2'b01)
                    cl_next = lane_pkg::CL_HS_RQST;
                else if (cl_s == 2'b10)
                    cl_next = lane_pkg::CL_ULTRA_LOW_POWER_STATE_RQST;
            lane_pkg::CL_HS_RQST:
                if (cl_s == 2'b00)
                    cl_next = lane_pkg::CL_HS_PREP;
                else if (cl_s != 2'b01)
                    cl_next = lane_pkg::CL_STOP;
            lane_pkg::CL_HS_PREP:
                if (cl_tmr == 8'(CL_TERM_CYC - 1))
                    cl_next = lane_pkg::CL_HS_CLK;
            lane_pkg::CL_HS_CLK:
                if (cl_s == 2'b11)
                    cl_next = lane_pkg::CL_STOP;
            lane_pkg::CL_ULTRA_LOW_POWER_STATE_RQST:
                if (cl_s == 2'b00)
                    cl_next = lane_pkg::CL_ULTRA_LOW_POWER_STATE;
                else if (cl_s != 2'b10)
                    cl_next = lane_pkg::CL_STOP;
            lane_pkg::CL_ULTRA_LOW_POWER_STATE:
                if (cl_s == 2'b10)
                    cl_next = lane_pkg::CL_ULTRA_LOW_POWER_STATE_EXIT;
            lane_pkg::CL_ULTRA_LOW_POWER_STATE_EXIT:
                if (cl_s == 2'b11)
                    cl_next = lane_pkg::CL_STOP;
            default:
                cl_next = lane_pkg::CL_INIT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cl_state_reg <= lane_pkg::CL_INIT;
            cl_tmr <= 8'h00;
            cl_term_en <= 1'b0;
            cl_hs_active <= 1'b0;
            cl_ultra_low_power_state_active <= 1'b0;
        end
        else
        begin
            cl_state_reg <= cl_next;
            cl_tmr <= (cl_next != cl_state_reg) ? 8'h00 : cl_tmr + 8'h01;
            cl_term_en <= (cl_next == lane_pkg::CL_HS_PREP) ||
                          (cl_next == lane_pkg::CL_HS_CLK);
            cl_hs_active <= (cl_next == lane_pkg::CL_HS_CLK);
            cl_ultra_low_power_state_active <= (cl_next == lane_pkg::CL_ULTRA_LOW_POWER_STATE);
        end
    end

    // rate may only move while no burst and no clock is running
    assign rate_ok = (dl_state_reg == lane_pkg::DL_INIT ||
                      dl_state_reg == lane_pkg::DL_STOP) &&
                     (cl_state_reg == lane_pkg::CL_INIT ||
                      cl_state_reg == lane_pkg::CL_STOP ||
                      cl_state_reg == lane_pkg::CL_ULTRA_LOW_POWER_STATE);

    always_ff @(posedge clk)
    begin
        if (rst)
            rate_reg <= `RATE_RESET;
        else if (rate_ok)
            rate_reg <= rate_cfg;
    end
    assign rate_applied = rate_reg;

    // no completion comes from the far end: the burst end closes it
    assign burst_end = (dl_state_reg == lane_pkg::DL_HS_RX) &&
                       (dl_next != lane_pkg::DL_HS_RX);
    assign cal_limit = cal_init ? 16'(CAL_INIT_CYC) : 16'(CAL_PER_CYC);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cal_run <= 1'b0;
            cal_init <= 1'b0;
            cal_seen <= 1'b0;
            cal_cnt <= 16'h0000;
            cal_done <= 1'b0;
            cal_overrun <= 1'b0;
        end
        else
        begin
            cal_done <= cal_run && burst_end;
            cal_overrun <= cal_run && cal_cnt == cal_limit;
            if (desk_pulse)
            begin
                cal_run <= 1'b1;
                cal_init <= !cal_seen;
                cal_cnt <= 16'h0000;
            end
            else if (cal_run && burst_end)
            begin
                cal_run <= 1'b0;
                cal_seen <= 1'b1;
            end
            else if (cal_run && cal_cnt != 16'hffff)
                cal_cnt <= cal_cnt + 16'h0001;
        end
    end
    assign deskew_active = cal_run;

    sequence s_esc_entry;
        dl_state_reg == lane_pkg::DL_ESC_RQST && lp_s == 2'b10 && !lp_oe.p
        ##1 lp_s == 2'b00;
    endsequence
    sequence s_prep_entry;
        dl_state_reg == lane_pkg::DL_HS_RQST && lp_s == 2'b00;
    endsequence

    a_term_enable_time: assert property (@(posedge clk) disable iff (rst)
        s_prep_entry |=> term_en ##TERM_CYC hs_active)
        else $error("termination or receive enable late");
    a_unidir_no_drive: assert property (@(posedge clk) disable iff (rst)
        unidir_reg && dl_state_reg == lane_pkg::DL_STOP |=> !lp_oe.p)
        else $error("lane driven with one-way partner");
    a_conflict_flag: assert property (@(posedge clk) disable iff (rst)
        lp_oe.p && dl_next != dl_state_reg && mism
        |=> contention && dl_state_reg == lane_pkg::DL_STOP && !lp_oe.p)
        else $error("conflict not flagged or drive kept");
    a_conflict_sticky: assert property (@(posedge clk) disable iff (rst)
        contention && !contention_ack |=> contention)
        else $error("contention flag lost without acknowledge");
    a_rate_frozen: assert property (@(posedge clk) disable iff (rst)
        hs_active || cl_hs_active |=> $stable(rate_reg))
        else $error("rate changed during a burst");
    a_esc_entry: assert property (@(posedge clk) disable iff (rst)
        s_esc_entry |=> esc_active)
        else $error("escape not entered");
    a_cal_overrun: assert property (@(posedge clk) disable iff (rst)
        cal_run && cal_cnt == cal_limit && !desk_pulse |=> cal_overrun)
        else $error("calibration overrun missed");
    a_cal_close: assert property (@(posedge clk) disable iff (rst)
        cal_run && burst_end && !desk_pulse |=> cal_done && !cal_run)
        else $error("calibration not closed at burst end");
    a_clock_lane_init: assert property (@(posedge clk) disable iff (rst)
        cl_state_reg == lane_pkg::CL_INIT && init_done
        |=> cl_state_reg == lane_pkg::CL_STOP)
        else $error("clock lane stuck in init");
    a_deskew_detect: assert property (@(posedge hs_clk) disable iff (hs_rst_s)
        en_s && !in_burst && !deskew_mode && hs_bit &&
        ones_cnt == 5'(`DESKEW_SYNC_UI - 1) |=> deskew_mode || !en_s)
        else $error("deskew sync not recognised");
    a_tail_dropped: assert property (@(posedge hs_clk) disable iff (hs_rst_s)
        !en_s |=> $stable(byte_tgl))
        else $error("byte delivered after burst end");
endmodule

// file: tb/lane_far_end.sv
// far-end transmitter model for the data and clock lanes
`timescale 1ns/1ps
module lane_far_end (
    output logic hs_clk,
    output logic hs_bit,
    output logic [1:0] lp,
    output logic [1:0] cl_lp
);
    initial
    begin
        hs_clk = 1'b0;
        hs_bit = 1'b0;
        lp = 2'b11;
        cl_lp = 2'b11;
    end
    // link clock runs only inside frames, for four tail clocks after each, and during reset
    task automatic tick(input int n);
        repeat (n)
        begin
            #40 hs_clk = 1'b1;
            #40 hs_clk = 1'b0;
        end
    endtask
    task automatic send(input logic b);
        hs_bit = b;
        tick(1);
    endtask
    // line states are timed with the link clock stopped
    task automatic set_lp(input logic [1:0] d, input logic [1:0] c);
        lp = d;
        cl_lp = c;
        #200;
    endtask
    // request, prepare, then hs-0 zero before the sync
    task automatic start();
        set_lp(2'b01, 2'b11);
        set_lp(2'b00, 2'b11);
        repeat (6) send(1'b0);
    endtask
    // own timing ends the burst, no acknowledge awaited
    task automatic finish();
        logic last;
        last = hs_bit;
        repeat (6) send(~last);
        lp = 2'b11;
        tick(4);
        hs_bit = ~hs_bit;
    endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the receive lane controller
`timescale 1ns/1ps
`include "lane_params.svh"
`define CHK(nm, e, s) \
    begin n_tests++; if ((s) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb_top;
    logic clk, rst, unidir_partner, turn_req, contention_ack;
    logic hs_clk, hs_bit, term_en, cl_term_en, hs_active, esc_active;
    logic cl_hs_active, cl_ultra_low_power_state_active, contention, deskew_active;
    logic cal_done, cal_overrun, far_off;
    logic [1:0] far_lp, cl_lp, lp_in, cd_in, lp_out, lp_oe;
    logic [15:0] rate_cfg, rate_applied, rate_exp;
    lane_pkg::rx_byte_s rx_byte;
    logic [7:0] exp_q[$];
    logic [7:0] d_seen;
    int n_fail, n_tests, n_done, n_over, cyc, seed, k;
    // opposite levels settle low; detector sees far end pulling high
    // a released far end leaves the line to its pull-up
    assign lp_in = (far_lp | {2{far_off}}) & (lp_out | ~lp_oe);
    assign cd_in = far_lp & ~{2{far_off}} & ~lp_out & lp_oe;
    lane_far_end far (.hs_clk(hs_clk), .hs_bit(hs_bit), .lp(far_lp),
        .cl_lp(cl_lp));
    lane_ctrl #(.INIT_CYC(50), .CAL_INIT_CYC(200)) uut (
        .clk(clk), .rst(rst), .hs_clk(hs_clk), .hs_bit(hs_bit),
        .lp_in(lp_in), .cd_in(cd_in), .cl_lp_in(cl_lp),
        .unidir_partner(unidir_partner), .turn_req(turn_req),
        .rate_cfg(rate_cfg), .contention_ack(contention_ack),
        .lp_out(lp_out), .lp_oe(lp_oe), .rx_byte(rx_byte),
        .rate_applied(rate_applied), .term_en(term_en),
        .cl_term_en(cl_term_en), .hs_active(hs_active),
        .esc_active(esc_active), .cl_hs_active(cl_hs_active),
        .cl_ultra_low_power_state_active(cl_ultra_low_power_state_active), .contention(contention),
        .deskew_active(deskew_active), .cal_done(cal_done),
        .cal_overrun(cal_overrun));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cal_done === 1'b1) n_done++;
        if (cal_overrun === 1'b1) n_over++;
        if (rx_byte.valid === 1'b1)
        begin
            d_seen = exp_q.size() ? exp_q.pop_front() : ~rx_byte.data;
            `CHK("rx_byte.data", d_seen, rx_byte.data)
        end
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // hs side resets through a synchroniser, so the link clock must tick
    task automatic do_reset(input logic u);
        @(posedge clk) rst <= 1'b1;
        unidir_partner <= u;
        far.tick(4);
        `CHK("idle", 7'h0, {hs_active, term_en, lp_oe, contention,
            deskew_active, esc_active})
        @(posedge clk) rst <= 1'b0;
        step(80);
    endtask
    task automatic new_rate();
        @(posedge clk) rate_cfg <= {12'($random(seed)), 4'h2};
        // an ack with nothing pending must not disturb the flag
        contention_ack <= 1'($random(seed));
        step(4);
        contention_ack <= 1'b0;
        `CHK("spurious", 1'b0, contention)
    endtask
    task automatic burst(input int nb);
        logic [7:0] s;
        s = `SYNC_BYTE;
        far.start();
        `CHK("term_hs", 2'b11, {term_en, hs_active})
        for (int i = 0; i < 8; i++) far.send(s[i]);
        repeat (nb)
        begin
            s = 8'($random(seed));
            exp_q.push_back(s);
            for (int i = 0; i < 8; i++) far.send(s[i]);
        end
        new_rate();
        `CHK("rate frozen", rate_exp, rate_applied)
        far.finish();
        step(10);
        `CHK("hs_active", 1'b0, hs_active)
        rate_exp = rate_cfg;
    endtask
    task automatic deskew(input int n);
        far.start();
        repeat (16) far.send(1'b1);
        far.send(1'b0);
        far.send(1'b1);
        `CHK("deskew_active", 1'b1, deskew_active)
        repeat (n) far.send(~hs_bit);
        far.finish();
        step(10);
    endtask
    initial
    begin
        seed = 92;
        rst = 1'b1;
        unidir_partner = 1'b0;
        turn_req = 1'b0;
        contention_ack = 1'b0;
        far_off = 1'b0;
        rate_cfg = {12'($random(seed)), 4'h2};
        do_reset(1'b0);
        `CHK("rate init", rate_cfg, rate_applied)
        rate_exp = rate_cfg;
        deskew(32);
        `CHK("overrun", 1, n_over)
        k = n_done;
        deskew(16);
        `CHK("cal_done", k + 1, n_done)
        $display("test deskew done");
        burst(3);
        $display("test burst done");
        far.set_lp(2'b11, 2'b01);
        far.set_lp(2'b11, 2'b00);
        `CHK("clock lane", 2'b11, {cl_term_en, cl_hs_active})
        new_rate();
        `CHK("rate frozen", rate_exp, rate_applied)
        far.set_lp(2'b11, 2'b11);
        `CHK("rate follows", rate_cfg, rate_applied)
        far.set_lp(2'b11, 2'b10);
        far.set_lp(2'b11, 2'b00);
        `CHK("cl_ultra_low_power_state_active", 1'b1, cl_ultra_low_power_state_active)
        far.set_lp(2'b11, 2'b10);
        far.set_lp(2'b11, 2'b11);
        `CHK("cl_ultra_low_power_state_active", 1'b0, cl_ultra_low_power_state_active)
        far.set_lp(2'b10, 2'b11);
        far.set_lp(2'b00, 2'b11);
        `CHK("esc_active", 1'b1, esc_active)
        far.set_lp(2'b11, 2'b11);
        $display("test lanes done");
        // far end lets go of the line while this side owns it
        @(posedge clk) turn_req <= 1'b1;
        far_off <= 1'b1;
        step(4);
        `CHK("lp_oe", 2'b11, lp_oe)
        @(posedge clk) turn_req <= 1'b0;
        step(40);
        `CHK("release", 3'b000, {lp_oe, contention})
        far_off <= 1'b0;
        @(posedge clk) turn_req <= 1'b1;
        far.set_lp(2'b00, 2'b11);
        @(posedge clk) turn_req <= 1'b0;
        step(4);
        `CHK("contention", 3'b001, {lp_oe, contention})
        far.set_lp(2'b11, 2'b11);
        `CHK("contention held", 1'b1, contention)
        @(posedge clk) contention_ack <= 1'b1;
        @(posedge clk) contention_ack <= 1'b0;
        step(3);
        `CHK("contention", 1'b0, contention)
        // far end keeps driving high while this side releases through 10
        @(posedge clk) turn_req <= 1'b1;
        @(posedge clk) turn_req <= 1'b0;
        step(20);
        `CHK("detector", 3'b001, {lp_oe, contention})
        $display("test contention done");
        do_reset(1'b1);
        @(posedge clk) turn_req <= 1'b1;
        step(4);
        `CHK("lp_oe", 2'b00, lp_oe)
        `CHK("bytes left", 0, exp_q.size())
        $display("test unidir done");
        tally_and_finish();
    end
endmodule
